// ---- include/umlft_cfg.svh ----
// offsets, field positions, reset values and timing counts of the mode and trigger block
// What this block does
// - loopback, infrared codec and test override together loop inverted infrared output to input.
// - loopback with test override clear feeds transmit data straight into receive data.
// - any loopback also ties modem control outputs back to modem status inputs.
// - loopback enable resets to zero.
// - normal infrared mode sends each zero bit as a 3/16 bit-period high pulse.
// - low-power mode pulse lasts three low-power reference periods, whatever the bit rate.
// - infrared codec off keeps infrared output low and ignores infrared input.
// - infrared codec on: plain transmit line held high, receive and modem inputs ignored.
// - infrared codec enable has no effect while the serial unit is disabled.
// - clearing the unit enable finishes the character in progress before stopping.
// - unit enabled moves data over plain pins or infrared pins per codec enable.
// - receive trigger fires at fill >= 1/8, 1/2, 1/2, 3/4, 7/8 per code.
// - transmit trigger fires at fill <= 1/8, 1/4, 1/2, 3/4, 7/8 per code.
// - both trigger fields reset to code 2, the half-full point.
// - with queues disabled each queue is one entry deep for trigger comparison.
`ifndef UMLFT_CFG_SVH
`define UMLFT_CFG_SVH
`define UMLFT_AW 12
`define UMLFT_OFF_CTRL 12'h030
`define UMLFT_OFF_IFLS 12'h034
`define UMLFT_OFF_TEST 12'h080
`define UMLFT_OFF_STAT 12'h0A0
`define UMLFT_OFF_CLR 12'h0A4
`define UMLFT_OFF_IEN 12'h0A8
`define UMLFT_OFF_RUN 12'h0AC
`define UMLFT_CTRL_EN_BIT 0
`define UMLFT_CTRL_IR_BIT 1
`define UMLFT_CTRL_LP_BIT 2
`define UMLFT_CTRL_LOOP_BIT 7
`define UMLFT_IFLS_TX_LSB 0
`define UMLFT_IFLS_RX_LSB 3
`define UMLFT_TEST_IR_BIT 0
`define UMLFT_STAT_RX_BIT 0
`define UMLFT_STAT_TX_BIT 1
`define UMLFT_CTRL_RST 1'b0
`define UMLFT_TRIG_RST 3'h2
`define UMLFT_SYNC_RST 7'h7B
`define UMLFT_NORM_PULSE_TICKS 2'h3
`define UMLFT_LP_PULSE_PERIODS 2'h3
`define UMLFT_BIT_TICKS 5'h10
`endif

// ---- include/umlft_pkg.sv ----
// types and trigger decoding shared by the mode and trigger block
package umlft_pkg;
	typedef logic [2:0] umlft_trig_code_t;
	typedef enum logic {ENC_IDLE = 1'b0, ENC_PULSE = 1'b1} umlft_enc_st_t;
	typedef enum logic {DEC_IDLE = 1'b0, DEC_LOW = 1'b1} umlft_dec_st_t;
	// returns {valid, threshold in eighths of depth}; reserved codes never trigger
	function automatic logic [3:0] umlft_eighths(input umlft_trig_code_t code, input logic is_rx);
		case (code)
			3'h0: umlft_eighths = 4'h9;
			3'h1: umlft_eighths = is_rx ? 4'hC : 4'hA;
			3'h2: umlft_eighths = 4'hC;
			3'h3: umlft_eighths = 4'hE;
			3'h4: umlft_eighths = 4'hF;
			default: umlft_eighths = 4'h0;
		endcase
	endfunction : umlft_eighths
endpackage : umlft_pkg

// ---- include/umlft_trig_if.sv ----
// fill level in, trigger state out, between the top and a trigger comparator
interface umlft_trig_if #(parameter int LW = 6);
	logic [LW-1:0] fill;
	umlft_pkg::umlft_trig_code_t code;
	logic queue_en;
	logic cond;
	logic hit;
	modport owner (output fill, output code, output queue_en, input cond, input hit);
	modport trig (input fill, input code, input queue_en, output cond, output hit);
endinterface : umlft_trig_if

// ---- hdl/umlft_trig.sv ----
// one queue trigger comparator: fill against a fraction of the queue depth
module umlft_trig import umlft_pkg::*; #(
	parameter int DEPTH = 32,
	parameter int LW = 6,
	parameter bit IS_RX = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// level and trigger
	umlft_trig_if.trig tif
);
	logic [3:0] sel;
	logic [LW-1:0] depth_eff;
	logic [LW+2:0] lhs;
	logic [LW+2:0] rhs;
	logic cond_q;

	always_comb begin
		sel = umlft_eighths(tif.code, IS_RX);
		// one-entry holding register when queues are off
		depth_eff = tif.queue_en ? LW'(DEPTH) : LW'(1);
		lhs = {tif.fill, 3'h0};
		rhs = (LW+3)'(sel[2:0]) * (LW+3)'(depth_eff);
		if (!sel[3]) begin
			tif.cond = 1'b0;
		end else if (IS_RX) begin
			tif.cond = lhs >= rhs;
		end else begin
			tif.cond = lhs <= rhs;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cond_q <= 1'b0;
		end else begin
			cond_q <= tif.cond;
		end
	end

	assign tif.hit = tif.cond & ~cond_q;
endmodule : umlft_trig

// ---- hdl/umlft_ir_enc.sv ----
// infrared pulse encoder: one short high pulse for each zero bit
`include "umlft_cfg.svh"
module umlft_ir_enc import umlft_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// controls
	input wire logic active,
	input wire logic low_power,
	// timing
	input wire logic bit_tick,
	input wire logic baud16_en,
	input wire logic lp_tick,
	// data
	input wire logic txd,
	output logic pulse
);
	umlft_enc_st_t st_q;
	logic [1:0] cnt_q;
	logic step;
	logic [1:0] last;

	assign step = low_power ? lp_tick : baud16_en;
	assign last = low_power ? `UMLFT_LP_PULSE_PERIODS - 2'h1 : `UMLFT_NORM_PULSE_TICKS - 2'h1;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= ENC_IDLE;
			cnt_q <= 2'h0;
		end else begin
			case (st_q)
				ENC_IDLE: begin
					if (active && bit_tick && !txd) begin
						st_q <= ENC_PULSE;
						cnt_q <= 2'h0;
					end
				end
				ENC_PULSE: begin
					if (!active) begin
						st_q <= ENC_IDLE;
					end else if (step) begin
						if (cnt_q == last) begin
							st_q <= ENC_IDLE;
						end else begin
							cnt_q <= cnt_q + 2'h1;
						end
					end
				end
				default: st_q <= ENC_IDLE;
			endcase
		end
	end

	assign pulse = (st_q == ENC_PULSE);
endmodule : umlft_ir_enc

// ---- hdl/umlft_top.sv ----
// mode, loopback and queue trigger control of a serial unit
`include "umlft_cfg.svh"
module umlft_top import umlft_pkg::*; #(
	parameter int FIFO_DEPTH = 32,
	parameter int FILL_W = $clog2(FIFO_DEPTH + 1)
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RSTN,
	// register port
	input wire logic [`UMLFT_AW-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	// interrupt
	output logic IRQ,
	// serial core, transmit side
	input wire logic CORE_TXD,
	input wire logic CORE_TX_BIT_TICK,
	input wire logic CORE_TX_BUSY,
	output logic CORE_TX_EN,
	// serial core, receive side
	input wire logic CORE_RX_BUSY,
	output logic CORE_RXD,
	output logic CORE_RX_EN,
	// serial core, timing and queues
	input wire logic BAUD16_EN,
	input wire logic QUEUE_EN,
	input wire logic [FILL_W-1:0] RX_FILL,
	input wire logic [FILL_W-1:0] TX_FILL,
	// serial core, modem signals
	input wire logic [3:0] CORE_MODEM_OUT_N,
	output logic [3:0] CORE_MODEM_IN_N,
	// plain serial pins
	output logic SERIAL_TX_LINE,
	input wire logic SERIAL_RX_LINE,
	output logic [3:0] MODEM_PIN_OUT_N,
	input wire logic [3:0] MODEM_PIN_IN_N,
	// infrared pins
	output logic IR_OUT_N,
	input wire logic IR_IN,
	input wire logic IR_LOWPOWER_REF_CLK
);
	// control and configuration
	logic loopback_en_q;
	logic ir_low_power_sel_q;
	logic ir_codec_en_q;
	logic serial_unit_en_q;
	logic ir_test_override_q;
	umlft_trig_code_t rx_trigger_level_q;
	umlft_trig_code_t tx_trigger_level_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_en_q;
	logic irq_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	// pin synchronisers
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	logic ref_prev_q;
	logic lp_tick;
	logic rx_pin_s;
	logic ir_pin_s;
	logic [3:0] modem_pin_s;
	// run state
	logic tx_run_q;
	logic rx_run_q;
	logic unit_on;
	logic ir_mode;
	logic ir_loop;
	logic plain_loop;
	// infrared path
	logic ir_pulse;
	logic ir_src;
	logic ir_src_prev_q;
	umlft_dec_st_t dec_st_q;
	logic [4:0] dec_cnt_q;
	// routed signals and output flops
	logic rxd_d;
	logic rxd_q;
	logic tx_line_q;
	logic ir_out_q;
	logic [3:0] modem_in_d;
	logic [3:0] modem_in_q;
	logic [3:0] modem_out_q;
	logic [1:0] stat_set;
	logic [1:0] stat_clr;
	logic wr_ctrl;
	logic wr_ifls;
	logic wr_test;
	logic wr_clr;
	logic wr_ien;

	function automatic logic hit_at(input logic [`UMLFT_AW-1:0] addr,
		input logic [`UMLFT_AW-1:0] off);
		hit_at = (addr == off);
	endfunction : hit_at

	umlft_trig_if #(.LW(FILL_W)) rx_tif ();
	umlft_trig_if #(.LW(FILL_W)) tx_tif ();

	assign rx_tif.fill = RX_FILL;
	assign rx_tif.code = rx_trigger_level_q;
	assign rx_tif.queue_en = QUEUE_EN;
	assign tx_tif.fill = TX_FILL;
	assign tx_tif.code = tx_trigger_level_q;
	assign tx_tif.queue_en = QUEUE_EN;

	umlft_trig #(.DEPTH(FIFO_DEPTH), .LW(FILL_W), .IS_RX(1'b1)) u_rx_trig (
		.clk(REF_CLK),
		.rstn(RSTN),
		.tif(rx_tif.trig)
	);

	umlft_trig #(.DEPTH(FIFO_DEPTH), .LW(FILL_W), .IS_RX(1'b0)) u_tx_trig (
		.clk(REF_CLK),
		.rstn(RSTN),
		.tif(tx_tif.trig)
	);

	// register write decode
	assign wr_ctrl = REG_WR & hit_at(REG_ADDR, `UMLFT_OFF_CTRL);
	assign wr_ifls = REG_WR & hit_at(REG_ADDR, `UMLFT_OFF_IFLS);
	assign wr_test = REG_WR & hit_at(REG_ADDR, `UMLFT_OFF_TEST);
	assign wr_clr = REG_WR & hit_at(REG_ADDR, `UMLFT_OFF_CLR);
	assign wr_ien = REG_WR & hit_at(REG_ADDR, `UMLFT_OFF_IEN);

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			loopback_en_q <= `UMLFT_CTRL_RST;
			ir_low_power_sel_q <= `UMLFT_CTRL_RST;
			ir_codec_en_q <= `UMLFT_CTRL_RST;
			serial_unit_en_q <= `UMLFT_CTRL_RST;
		end else if (wr_ctrl) begin
			loopback_en_q <= REG_WDATA[`UMLFT_CTRL_LOOP_BIT];
			ir_low_power_sel_q <= REG_WDATA[`UMLFT_CTRL_LP_BIT];
			ir_codec_en_q <= REG_WDATA[`UMLFT_CTRL_IR_BIT];
			serial_unit_en_q <= REG_WDATA[`UMLFT_CTRL_EN_BIT];
		end
	end

	// reserved codes are stored as written; they simply never trigger
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rx_trigger_level_q <= `UMLFT_TRIG_RST;
			tx_trigger_level_q <= `UMLFT_TRIG_RST;
		end else if (wr_ifls) begin
			rx_trigger_level_q <= REG_WDATA[`UMLFT_IFLS_RX_LSB +: 3];
			tx_trigger_level_q <= REG_WDATA[`UMLFT_IFLS_TX_LSB +: 3];
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ir_test_override_q <= `UMLFT_CTRL_RST;
		end else if (wr_test) begin
			ir_test_override_q <= REG_WDATA[`UMLFT_TEST_IR_BIT];
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			irq_en_q <= 2'h0;
		end else if (wr_ien) begin
			irq_en_q <= REG_WDATA[1:0];
		end
	end

	// sticky status: a new event beats a clear in the same cycle
	assign stat_set[`UMLFT_STAT_RX_BIT] = rx_tif.hit;
	assign stat_set[`UMLFT_STAT_TX_BIT] = tx_tif.hit;
	assign stat_clr = wr_clr ? REG_WDATA[1:0] : 2'h0;

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			irq_stat_q <= 2'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~stat_clr) | stat_set;
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(((irq_stat_q & ~stat_clr) | stat_set) & irq_en_q);
		end
	end

	// read data: valid only in the cycle after the strobe, zero otherwise
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (REG_ADDR)
			`UMLFT_OFF_CTRL: begin
				rdata_d[`UMLFT_CTRL_LOOP_BIT] = loopback_en_q;
				rdata_d[`UMLFT_CTRL_LP_BIT] = ir_low_power_sel_q;
				rdata_d[`UMLFT_CTRL_IR_BIT] = ir_codec_en_q;
				rdata_d[`UMLFT_CTRL_EN_BIT] = serial_unit_en_q;
			end
			`UMLFT_OFF_IFLS: begin
				rdata_d[`UMLFT_IFLS_RX_LSB +: 3] = rx_trigger_level_q;
				rdata_d[`UMLFT_IFLS_TX_LSB +: 3] = tx_trigger_level_q;
			end
			`UMLFT_OFF_TEST: rdata_d[`UMLFT_TEST_IR_BIT] = ir_test_override_q;
			`UMLFT_OFF_STAT: rdata_d[1:0] = irq_stat_q;
			`UMLFT_OFF_IEN: rdata_d[1:0] = irq_en_q;
			`UMLFT_OFF_RUN: rdata_d[3:0] = {tx_tif.cond, rx_tif.cond, rx_run_q, tx_run_q};
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rdata_q <= 32'h0000_0000;
		end else if (REG_RD) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end

	// pin synchronisers; first stage read only by the second
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sync1_q <= `UMLFT_SYNC_RST;
			sync2_q <= `UMLFT_SYNC_RST;
		end else begin
			sync1_q <= {MODEM_PIN_IN_N, IR_LOWPOWER_REF_CLK, IR_IN, SERIAL_RX_LINE};
			sync2_q <= sync1_q;
		end
	end

	assign rx_pin_s = sync2_q[0];
	assign ir_pin_s = sync2_q[1];
	assign modem_pin_s = sync2_q[6:3];

	// low-power reference: one tick per rising edge, slow enough to sample
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ref_prev_q <= 1'b0;
		end else begin
			ref_prev_q <= sync2_q[2];
		end
	end

	assign lp_tick = sync2_q[2] & ~ref_prev_q;

	// disabling mid-character keeps each direction running until its busy drops
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			tx_run_q <= 1'b0;
			rx_run_q <= 1'b0;
		end else begin
			tx_run_q <= serial_unit_en_q | (tx_run_q & CORE_TX_BUSY);
			rx_run_q <= serial_unit_en_q | (rx_run_q & CORE_RX_BUSY);
		end
	end

	assign unit_on = tx_run_q | rx_run_q;
	assign ir_mode = unit_on & ir_codec_en_q;
	assign ir_loop = loopback_en_q & ir_codec_en_q & ir_test_override_q;
	assign plain_loop = loopback_en_q & ~ir_test_override_q;

	umlft_ir_enc u_ir_enc (
		.clk(REF_CLK),
		.rstn(RSTN),
		.active(ir_mode & tx_run_q),
		.low_power(ir_low_power_sel_q),
		.bit_tick(CORE_TX_BIT_TICK),
		.baud16_en(BAUD16_EN),
		.lp_tick(lp_tick),
		.txd(CORE_TXD),
		.pulse(ir_pulse)
	);

	// infrared receive source: the inverted transmit pulse in infrared loopback
	assign ir_src = ir_loop ? ~ir_pulse : ir_pin_s;

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ir_src_prev_q <= 1'b1;
		end else begin
			ir_src_prev_q <= ir_src;
		end
	end

	// decoder stretches each received low pulse to one full bit
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			dec_st_q <= DEC_IDLE;
			dec_cnt_q <= 5'h00;
		end else begin
			case (dec_st_q)
				DEC_IDLE: begin
					if (ir_mode && rx_run_q && ir_src_prev_q && !ir_src) begin
						dec_st_q <= DEC_LOW;
						dec_cnt_q <= 5'h00;
					end
				end
				DEC_LOW: begin
					if (!ir_mode) begin
						dec_st_q <= DEC_IDLE;
					end else if (BAUD16_EN) begin
						if (dec_cnt_q == `UMLFT_BIT_TICKS - 5'h01) begin
							dec_st_q <= DEC_IDLE;
						end else begin
							dec_cnt_q <= dec_cnt_q + 5'h01;
						end
					end
				end
				default: dec_st_q <= DEC_IDLE;
			endcase
		end
	end

	// receive routing: plain loopback first, then infrared, then the plain pin
	always_comb begin
		if (plain_loop) begin
			rxd_d = CORE_TXD;
		end else if (ir_mode) begin
			rxd_d = (dec_st_q != DEC_LOW);
		end else if (rx_run_q) begin
			rxd_d = rx_pin_s;
		end else begin
			rxd_d = 1'b1;
		end
	end

	// modem status: outputs looped back, ignored while in infrared mode
	always_comb begin
		if (loopback_en_q) begin
			modem_in_d = CORE_MODEM_OUT_N;
		end else if (ir_mode) begin
			modem_in_d = 4'hF;
		end else begin
			modem_in_d = modem_pin_s;
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rxd_q <= 1'b1;
			modem_in_q <= 4'hF;
			modem_out_q <= 4'hF;
		end else begin
			rxd_q <= rxd_d;
			modem_in_q <= modem_in_d;
			modem_out_q <= CORE_MODEM_OUT_N;
		end
	end

	// pins: plain line marks while infrared is in use or the unit is stopped
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			tx_line_q <= 1'b1;
			ir_out_q <= 1'b0;
		end else begin
			tx_line_q <= (ir_mode || !tx_run_q) ? 1'b1 : CORE_TXD;
			ir_out_q <= ir_mode & ir_pulse;
		end
	end

	assign SERIAL_TX_LINE = tx_line_q;
	assign IR_OUT_N = ir_out_q;
	assign MODEM_PIN_OUT_N = modem_out_q;
	assign CORE_RXD = rxd_q;
	assign CORE_MODEM_IN_N = modem_in_q;
	assign CORE_TX_EN = tx_run_q;
	assign CORE_RX_EN = rx_run_q;
	assign REG_RDATA = rdata_q;
	assign IRQ = irq_q;
endmodule : umlft_top

// ---- dv/umlft_peer.sv ----
// far-side model: serial peer line, modem pins and infrared receiver
module umlft_peer (
	// clock
	input wire logic clk,
	// line side
	output logic rx_line,
	output logic ir_rx,
	output logic [3:0] modem_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// lines idle at mark level and modem pins inactive high
	initial begin
		rx_line = 1'b1;
		ir_rx = 1'b1;
		modem_n = 4'hF;
	end
	task automatic send_line(input logic v, input logic [3:0] m);
		@(posedge clk);
		rx_line <= v;
		modem_n <= m;
	endtask : send_line
	// a received zero is a short low pulse on the idle-high detector output
	task automatic ir_zero(input int n);
		@(posedge clk);
		ir_rx <= 1'b0;
		repeat (n) @(posedge clk);
		ir_rx <= 1'b1;
	endtask : ir_zero
endmodule : umlft_peer

// ---- dv/umlft_checker.sv ----
// port-level assertions of the mode and trigger block
`include "umlft_cfg.svh"
module umlft_checker #(
	parameter int FIFO_DEPTH = 32,
	parameter int FILL_W = 6
) (
	// clock, reset and register port
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic [`UMLFT_AW-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic IRQ,
	// serial core side
	input wire logic CORE_TXD,
	input wire logic CORE_TX_BUSY,
	input wire logic CORE_TX_EN,
	input wire logic CORE_RX_EN,
	input wire logic CORE_RXD,
	input wire logic QUEUE_EN,
	input wire logic [FILL_W-1:0] RX_FILL,
	input wire logic [3:0] CORE_MODEM_OUT_N,
	input wire logic [3:0] CORE_MODEM_IN_N,
	// pins
	input wire logic SERIAL_TX_LINE,
	input wire logic IR_OUT_N
);
	logic [3:0] ctrl_q;
	logic [2:0] rxc_q;
	logic [1:0] age_q;
	logic test_q;
	logic ien_q;
	logic ifls_wr_q;
	logic [3:0] k;
	logic rx_cond;
	logic cfg_wr;
	assign cfg_wr = REG_WR && REG_ADDR inside {`UMLFT_OFF_CTRL, `UMLFT_OFF_IFLS,
		`UMLFT_OFF_TEST, `UMLFT_OFF_IEN};
	// shadow of written settings, since the design's registers are hidden from here
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_q <= 4'h0;
			rxc_q <= 3'h2;
			test_q <= 1'b0;
			ien_q <= 1'b0;
			ifls_wr_q <= 1'b0;
		end else if (REG_WR) begin
			if (REG_ADDR == `UMLFT_OFF_CTRL)
				ctrl_q <= {REG_WDATA[7], REG_WDATA[2:0]};
			if (REG_ADDR == `UMLFT_OFF_IFLS)
				rxc_q <= REG_WDATA[5:3];
			if (REG_ADDR == `UMLFT_OFF_IFLS)
				ifls_wr_q <= 1'b1;
			if (REG_ADDR == `UMLFT_OFF_TEST)
				test_q <= REG_WDATA[0];
			if (REG_ADDR == `UMLFT_OFF_IEN)
				ien_q <= REG_WDATA[0];
		end
	end
	// settle time, so that routing is not judged while it switches
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN)
			age_q <= 2'h0;
		else if (cfg_wr)
			age_q <= 2'h0;
		else if (age_q != 2'h3)
			age_q <= age_q + 2'h1;
	end
	always_comb begin
		case (rxc_q)
			3'h0: k = 4'h1;
			3'h1, 3'h2: k = 4'h4;
			3'h3: k = 4'h6;
			3'h4: k = 4'h7;
			default: k = 4'h0;
		endcase
	end
	assign rx_cond = (k != 4'h0) && (32'(RX_FILL) * 8 >= 32'(k) * (QUEUE_EN ? FIFO_DEPTH : 1));
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	AST_LOOP_DATA: assert property (ctrl_q == 4'h9 && !test_q && age_q == 2'h3
		|-> CORE_RXD == $past(CORE_TXD)) else $error("loop data differs");
	AST_LOOP_MODEM: assert property (ctrl_q[3] && ctrl_q[1:0] == 2'h1 && age_q == 2'h3
		|-> CORE_MODEM_IN_N == $past(CORE_MODEM_OUT_N)) else $error("modem loop differs");
	AST_IR_OFF: assert property (!ctrl_q[1] && age_q == 2'h3 |-> !IR_OUT_N)
		else $error("infrared output active while codec off");
	AST_IR_MARK: assert property (ctrl_q[1:0] == 2'h3 && age_q == 2'h3
		|-> SERIAL_TX_LINE && (ctrl_q[3] || CORE_MODEM_IN_N == 4'hF))
		else $error("plain line or modem inputs not quiet in infrared mode");
	AST_UNIT_OFF: assert property (ctrl_q[1:0] == 2'h2 && age_q == 2'h3
		|-> SERIAL_TX_LINE && !IR_OUT_N) else $error("disabled unit drives lines");
	AST_RUN_HOLD: assert property (CORE_TX_EN && CORE_TX_BUSY |=> CORE_TX_EN)
		else $error("transmit stopped mid character");
	AST_RUN_STOP: assert property (!ctrl_q[0] && age_q == 2'h3 && !CORE_TX_BUSY
		|=> !CORE_TX_EN) else $error("transmit run not stopped");
	AST_RUN_ON: assert property (ctrl_q[0] && age_q == 2'h3 |-> CORE_TX_EN && CORE_RX_EN)
		else $error("enabled unit not running");
	AST_TRIG_RST: assert property (REG_RD && REG_ADDR == `UMLFT_OFF_IFLS && !ifls_wr_q
		|=> REG_RDATA == 32'h12) else $error("trigger reset value wrong");
	AST_RX_IRQ: assert property (ien_q && age_q == 2'h3 && $rose(rx_cond)
		|-> ##[1:2] IRQ) else $error("receive interrupt missing");
endmodule : umlft_checker
bind umlft_top umlft_checker #(.FIFO_DEPTH(FIFO_DEPTH), .FILL_W(FILL_W)) u_checker (
	.REF_CLK(REF_CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ),
	.CORE_TXD(CORE_TXD), .CORE_TX_BUSY(CORE_TX_BUSY), .CORE_TX_EN(CORE_TX_EN),
	.CORE_RX_EN(CORE_RX_EN), .CORE_RXD(CORE_RXD), .QUEUE_EN(QUEUE_EN), .RX_FILL(RX_FILL),
	.CORE_MODEM_OUT_N(CORE_MODEM_OUT_N), .CORE_MODEM_IN_N(CORE_MODEM_IN_N),
	.SERIAL_TX_LINE(SERIAL_TX_LINE), .IR_OUT_N(IR_OUT_N));

// ---- dv/uart_mode_loopback_fifo_trigger_tb.sv ----
// self-checking bench of the mode, loopback and trigger block
`include "umlft_cfg.svh"
module uart_mode_loopback_fifo_trigger_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEPTH = 32;
	logic ref_clk, rstn, reg_wr, reg_rd, irq, core_txd, tx_tick, tx_busy, tx_en, rx_busy;
	logic core_rxd, rx_en, baud16, queue_en, lp_ref, tx_line, ir_out, rx_line, ir_in;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd_q, cyc;
	logic [5:0] rx_fill, tx_fill, v;
	logic [3:0] mdm_out, mdm_in, pin_out, pin_in;
	logic [4:0] e;
	int n_fail, n_checks, w, l;
	umlft_top #(.FIFO_DEPTH(DEPTH)) uut (.REF_CLK(ref_clk), .RSTN(rstn), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.IRQ(irq), .CORE_TXD(core_txd), .CORE_TX_BIT_TICK(tx_tick), .CORE_TX_BUSY(tx_busy),
		.CORE_TX_EN(tx_en), .CORE_RX_BUSY(rx_busy), .CORE_RXD(core_rxd), .CORE_RX_EN(rx_en),
		.BAUD16_EN(baud16), .QUEUE_EN(queue_en), .RX_FILL(rx_fill), .TX_FILL(tx_fill),
		.CORE_MODEM_OUT_N(mdm_out), .CORE_MODEM_IN_N(mdm_in), .SERIAL_TX_LINE(tx_line),
		.SERIAL_RX_LINE(rx_line), .MODEM_PIN_OUT_N(pin_out), .MODEM_PIN_IN_N(pin_in),
		.IR_OUT_N(ir_out), .IR_IN(ir_in), .IR_LOWPOWER_REF_CLK(lp_ref));
	umlft_peer peer (.clk(ref_clk), .rx_line(rx_line), .ir_rx(ir_in), .modem_n(pin_in));
	always #5 ref_clk = ~ref_clk;
	// 16x tick every 4 cycles; low-power reference of 8 cycles, well below a quarter clock
	always @(posedge ref_clk) begin
		cyc <= cyc + 32'h1;
		baud16 <= (cyc[1:0] == 2'h3);
		lp_ref <= cyc[2];
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		rd_q = reg_rdata;
	endtask : rd
	task automatic watch(input int n, output int hi, output int lo);
		hi = 0;
		lo = 0;
		repeat (n) begin
			tick(1);
			hi += (ir_out === 1'b1);
			lo += (core_rxd === 1'b0);
		end
	endtask : watch
	task automatic ir_bit(input logic b);
		@(posedge ref_clk);
		tx_tick <= 1'b1;
		core_txd <= b;
		@(posedge ref_clk);
		tx_tick <= 1'b0;
		watch(90, w, l);
	endtask : ir_bit
	function automatic int thr(input logic is_rx, input int c, input int d);
		int k;
		k = (c == 0) ? 1 : (c >= 3) ? c + 3 : (is_rx || c == 2) ? 4 : 2;
		return is_rx ? (k * d + 7) / 8 : k * d / 8;
	endfunction : thr
	task automatic fill(input logic is_rx, input int f);
		@(posedge ref_clk);
		if (is_rx)
			rx_fill <= 6'(f);
		else
			tx_fill <= 6'(f);
	endtask : fill
	// a miss level, then the exact threshold; reserved codes get the extremes
	task automatic trig_case(input logic is_rx, input int c, input logic qen);
		int t;
		int miss;
		t = thr(is_rx, c, qen ? DEPTH : 1);
		miss = (c > 4) ? (is_rx ? 0 : DEPTH) : (is_rx ? t - 1 : t + 1);
		if (c > 4)
			t = is_rx ? DEPTH : 0;
		@(posedge ref_clk);
		queue_en <= qen;
		wr(`UMLFT_OFF_IFLS, is_rx ? c << 3 : c);
		fill(is_rx, miss);
		tick(3);
		wr(`UMLFT_OFF_CLR, 3);
		wr(`UMLFT_OFF_IEN, is_rx ? 1 : 2);
		tick(2);
		check(irq, 0);
		fill(is_rx, t);
		tick(3);
		check(irq, c < 5);
		rd(`UMLFT_OFF_STAT);
		check(rd_q[is_rx ? 0 : 1], c < 5);
		wr(`UMLFT_OFF_CLR, 3);
		tick(2);
		check(irq, 0);
	endtask : trig_case
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (40000) @(posedge ref_clk);
		n_fail++;
		wrap_up();
	end
	initial begin
		{ref_clk, rstn, reg_wr, reg_rd, tx_tick, tx_busy, rx_busy} = '0;
		{reg_addr, reg_wdata, rx_fill, tx_fill, mdm_out, cyc, baud16, lp_ref} = '0;
		core_txd = 1'b1;
		queue_en = 1'b1;
		n_fail = 0;
		n_checks = 0;
		rd_q = $urandom(32'hA4E79169);
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(`UMLFT_OFF_CTRL);
		check(rd_q, 0);
		rd(`UMLFT_OFF_IFLS);
		check(rd_q, 32'h12);
		rd(12'h100);
		check(rd_q, 0);
		v = {3'($urandom_range(4)), 3'($urandom_range(4))};
		wr(`UMLFT_OFF_IFLS, v);
		rd(`UMLFT_OFF_IFLS);
		check(rd_q, v);
		$display("test registers done");
		for (int q = 1; q >= 0; q--)
			for (int r = 0; r < 2; r++)
				for (int c = 0; c < 5; c++)
					trig_case(r[0], c, q[0]);
		trig_case(1'b1, 5, 1'b1);
		trig_case(1'b0, 7, 1'b1);
		repeat (4) trig_case(1'($urandom), $urandom_range(4), 1'b1);
		$display("test triggers done");
		wr(`UMLFT_OFF_CTRL, 32'h81);
		tick(3);
		repeat (20) begin
			@(posedge ref_clk);
			e = {core_txd, mdm_out};
			core_txd <= 1'($urandom);
			mdm_out <= 4'($urandom);
			#1;
			check(core_rxd, e[4]);
			check(mdm_in, e[3:0]);
			check(pin_out, e[3:0]);
		end
		$display("test loopback done");
		wr(`UMLFT_OFF_CTRL, 32'h01);
		peer.send_line(1'b0, 4'h5);
		tick(6);
		check(core_rxd, 0);
		check(mdm_in, 4'h5);
		check(tx_line, core_txd);
		peer.send_line(1'b1, 4'hF);
		// let the released line pass the synchroniser before counting lows
		tick(4);
		fork
			peer.ir_zero(4);
			watch(90, w, l);
		join
		check(w, 0);
		check(l, 0);
		$display("test plain pins done");
		wr(`UMLFT_OFF_CTRL, 32'h03);
		peer.send_line(1'b0, 4'h0);
		tick(6);
		check(tx_line, 1);
		check(mdm_in, 4'hF);
		check(core_rxd, 1);
		fork
			peer.ir_zero(4);
			watch(90, w, l);
		join
		check(l >= 56 && l <= 68, 1);
		ir_bit(1'b0);
		check(w >= 8 && w <= 16, 1);
		ir_bit(1'b1);
		check(w, 0);
		wr(`UMLFT_OFF_CTRL, 32'h07);
		ir_bit(1'b0);
		check(w >= 16 && w <= 28, 1);
		wr(`UMLFT_OFF_TEST, 1);
		wr(`UMLFT_OFF_CTRL, 32'h83);
		ir_bit(1'b0);
		check(l >= 56 && l <= 68, 1);
		wr(`UMLFT_OFF_TEST, 0);
		peer.send_line(1'b1, 4'hF);
		wr(`UMLFT_OFF_CTRL, 32'h02);
		ir_bit(1'b0);
		check(w, 0);
		check(tx_line, 1);
		$display("test infrared done");
		wr(`UMLFT_OFF_CTRL, 32'h01);
		@(posedge ref_clk);
		tx_busy <= 1'b1;
		rx_busy <= 1'b1;
		wr(`UMLFT_OFF_CTRL, 32'h00);
		tick(4);
		check(tx_en, 1);
		check(rx_en, 1);
		rd(`UMLFT_OFF_RUN);
		check(rd_q[1:0], 2'h3);
		@(posedge ref_clk);
		tx_busy <= 1'b0;
		rx_busy <= 1'b0;
		tick(3);
		check(tx_en, 0);
		check(rx_en, 0);
		rd(`UMLFT_OFF_RUN);
		check(rd_q[1:0], 2'h0);
		$display("test disable done");
		wrap_up();
	end
endmodule : uart_mode_loopback_fifo_trigger_tb
